// file: logic/pmr_bank.sv
`timescale 1ns/100ps
// Operation
// R1: Control bit 3 turns off automatic crossover
// R2: Control bit 2 stops far-end fault detection
// R3: Control bit 1 suppresses port transmission
// R4: Control bit 0 switches the indicator off
// R5: Status bit 15 reads zero
// R6: Status bits 14 to 11 read one
// R7: Status bit 0, bits 10-7 read zero
// R8: Status bit 5 shows negotiation finished
// R9: Status bit 4 shows far-end fault
// R10: Status bit 3 reads one
// R11: Status bit 2 shows link up
// R12: Two read-only identifier registers at 2h, 3h
// R13: Negotiation_advertise bit 10 pause, read/write, resets one
// R14: Negotiation_advertise bits 8-5 abilities, reset one
// R15: Selector reads 00001, bits 15-11 zero
// R16: Partner bits 15 to 11 read zero
// R17: Partner bit 10 shows partner pause
// R18: Control bit 12 enables negotiation, resets one
module pmr_bank #(
  parameter logic [15:0] ID_HIGH = pmr_pkg::ID_HIGH_DEF,
  parameter logic [15:0] ID_LOW = pmr_pkg::ID_LOW_DEF
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [pmr_pkg::ADDR_W-1:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [pmr_pkg::DATA_W-1:0] mgmt_wdata,
  output logic [pmr_pkg::DATA_W-1:0] mgmt_rdata,
  output logic mgmt_rvalid,
  input wire logic an_done_in,
  input wire logic far_fault_in,
  input wire logic link_up_in,
  input wire logic partner_valid,
  input wire logic [pmr_pkg::DATA_W-1:0] partner_word,
  output logic crossover_auto_off,
  output logic fef_detect_off,
  output logic transmit_off,
  output logic indicator_off,
  output logic negotiation_on,
  output logic [pmr_pkg::DATA_W-1:0] adv_word,
  output logic partner_pause
);
  import pmr_pkg::*;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [4:0] a, input logic [4:0] t);
    hit = (a == t);
  endfunction

  logic wr_ctrl;
  logic wr_adv;
  logic adv_pause;
  logic [3:0] adv_abil;
  logic negotiation_done;
  logic stat_fef;
  logic stat_link;
  logic lp_pause;
  logic [3:0] lp_abil;
  logic [15:0] ctrl_word;
  logic [15:0] stat_word;
  logic [15:0] lp_word;
  logic [15:0] next_rdata;

  // Write strobes per writable register
  assign wr_ctrl = mgmt_wr && hit(mgmt_addr, ADDR_CTRL);
  assign wr_adv = mgmt_wr && hit(mgmt_addr, ADDR_ADV);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Writable control bits, others left at zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      negotiation_on <= RST_AN_ON;
      crossover_auto_off <= RST_CTRL_LOW;
      fef_detect_off <= RST_CTRL_LOW;
      transmit_off <= RST_CTRL_LOW;
      indicator_off <= RST_CTRL_LOW;
    end else if (wr_ctrl) begin
      negotiation_on <= mgmt_wdata[CTRL_AN_ON]; // see R18
      crossover_auto_off <= mgmt_wdata[CTRL_XOVER_OFF]; // see R1
      fef_detect_off <= mgmt_wdata[CTRL_FEF_OFF]; // see R2
      transmit_off <= mgmt_wdata[CTRL_TX_OFF]; // see R3
      indicator_off <= mgmt_wdata[CTRL_LED_OFF]; // see R4
    end
  end

  // Control read image
  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[CTRL_AN_ON] = negotiation_on;
    ctrl_word[CTRL_XOVER_OFF] = crossover_auto_off;
    ctrl_word[CTRL_FEF_OFF] = fef_detect_off;
    ctrl_word[CTRL_TX_OFF] = transmit_off;
    ctrl_word[CTRL_LED_OFF] = indicator_off;
  end

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  // Live status sampled each clock
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      negotiation_done <= 1'h0;
      stat_fef <= 1'h0;
      stat_link <= 1'h0;
    end else begin
      negotiation_done <= an_done_in && negotiation_on; // see R8
      stat_fef <= far_fault_in && !fef_detect_off; // see R9
      stat_link <= link_up_in; // see R11
    end
  end

  // Status read image with fixed abilities
  always_comb begin
    stat_word = 16'h0000;
    stat_word[STAT_T4] = 1'h0; // see R5
    stat_word[STAT_CAP_HI:STAT_CAP_LO] = STAT_CAP_VAL; // see R6
    stat_word[STAT_RSV_HI:STAT_RSV_LO] = 4'h0; // see R7
    stat_word[STAT_EXT] = 1'h0; // see R7
    stat_word[STAT_DONE] = negotiation_done;
    stat_word[STAT_FEF] = stat_fef;
    stat_word[STAT_AN_ABLE] = 1'h1; // see R10
    stat_word[STAT_LINK] = stat_link;
  end

  // ----------------------------------------------------------------
  // Negotiation_advertise register
  // ----------------------------------------------------------------
  // Pause and ability bits
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      adv_pause <= RST_ADV_PAUSE;
      adv_abil <= RST_ADV_ABIL;
    end else if (wr_adv) begin
      adv_pause <= mgmt_wdata[ADV_PAUSE]; // see R13
      adv_abil <= mgmt_wdata[ADV_ABIL_HI:ADV_ABIL_LO]; // see R14
    end
  end

  // Code word offered to the negotiation engine
  always_comb begin
    adv_word = 16'h0000; // see R15
    adv_word[ADV_PAUSE] = adv_pause;
    adv_word[ADV_ABIL_HI:ADV_ABIL_LO] = adv_abil;
    adv_word[ADV_SEL_HI:0] = SEL_8023; // see R15
  end

  // ----------------------------------------------------------------
  // Partner ability register
  // ----------------------------------------------------------------
  pmr_partner_capture u_partner (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .link_up(link_up_in),
    .word_valid(partner_valid),
    .word(partner_word),
    .pause(lp_pause),
    .abil(lp_abil)
  );

  assign partner_pause = lp_pause;

  // Partner read image, upper bits unsupported
  always_comb begin
    lp_word = 16'h0000; // see R16
    lp_word[LP_PAUSE] = lp_pause; // see R17
    lp_word[ADV_ABIL_HI:ADV_ABIL_LO] = lp_abil;
    lp_word[ADV_SEL_HI:0] = SEL_8023;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read select, unmapped reads return zero
  always_comb begin
    if (hit(mgmt_addr, ADDR_CTRL)) begin
      next_rdata = ctrl_word;
    end else if (hit(mgmt_addr, ADDR_STAT)) begin
      next_rdata = stat_word;
    end else if (hit(mgmt_addr, ADDR_IDH)) begin
      next_rdata = ID_HIGH; // see R12
    end else if (hit(mgmt_addr, ADDR_IDL)) begin
      next_rdata = ID_LOW; // see R12
    end else if (hit(mgmt_addr, ADDR_ADV)) begin
      next_rdata = adv_word;
    end else if (hit(mgmt_addr, ADDR_LP)) begin
      next_rdata = lp_word;
    end else begin
      next_rdata = 16'h0000;
    end
  end

  // Registered read data and strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mgmt_rdata <= 16'h0000;
      mgmt_rvalid <= 1'h0;
    end else begin
      mgmt_rvalid <= mgmt_rd;
      if (mgmt_rd) begin
        mgmt_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  AST_XOVER_WRITE: assert property ( // see R1
    wr_ctrl |=> crossover_auto_off == $past(mgmt_wdata[CTRL_XOVER_OFF]))
    else $error("crossover control not updated");
  AST_FEF_OFF: assert property ( // see R2
    fef_detect_off && $past(fef_detect_off) |-> !stat_fef)
    else $error("far-end fault seen while detection off");
  AST_TX_HOLD: assert property ( // see R3
    !wr_ctrl |=> $stable(transmit_off))
    else $error("transmit control changed without write");
  AST_LED_WRITE: assert property ( // see R4
    wr_ctrl ##1 !wr_ctrl |=>
      indicator_off == $past(mgmt_wdata[CTRL_LED_OFF], 2))
    else $error("indicator control not held");
  AST_STAT_FIXED: assert property ( // see R5 R6 R7 R10
    mgmt_rd && hit(mgmt_addr, ADDR_STAT) |=>
      mgmt_rvalid && mgmt_rdata[15:11] == 5'h0F &&
      mgmt_rdata[10:7] == 4'h0 && mgmt_rdata[3] && !mgmt_rdata[0])
    else $error("fixed status bits wrong");
  AST_DONE_FOLLOW: assert property ( // see R8
    an_done_in && negotiation_on |=> negotiation_done)
    else $error("negotiation done not reported");
  AST_FEF_FOLLOW: assert property ( // see R9
    far_fault_in && !fef_detect_off |=> stat_fef)
    else $error("far-end fault not reported");
  AST_LINK_FOLLOW: assert property ( // see R11
    $rose(link_up_in) |=> stat_link ##0 !$past(stat_link))
    else $error("link status did not follow");
  AST_ID_READ: assert property ( // see R12
    mgmt_rd && hit(mgmt_addr, ADDR_IDL) |=> mgmt_rdata == ID_LOW)
    else $error("identifier read wrong");
  AST_ADV_WRITE: assert property ( // see R13 R14
    wr_adv |=> adv_word[10:5] ==
      {$past(mgmt_wdata[10]), 1'h0, $past(mgmt_wdata[8:5])})
    else $error("negotiation_advertise not updated");
  AST_ADV_FIXED: assert property ( // see R15
    adv_word[15:11] == 5'h00 && adv_word[4:0] == 5'h01)
    else $error("negotiation_advertise fixed bits wrong");
  AST_LP_UPPER: assert property ( // see R16
    mgmt_rd && hit(mgmt_addr, ADDR_LP) |=> mgmt_rdata[15:11] == 5'h00)
    else $error("partner upper bits not zero");
  AST_AN_OFF: assert property ( // see R18
    !negotiation_on |=> !negotiation_done)
    else $error("done reported with negotiation off");

  // Read images of status, control, identifiers and code words; code word hold and read answer
  AST_IDH_READ: assert property ( // see R12
    mgmt_rd && hit(mgmt_addr, ADDR_IDH) |=> mgmt_rdata == ID_HIGH)
    else $error("high identifier read wrong");
  AST_T4_READ: assert property ( // see R5
    mgmt_rd && hit(mgmt_addr, ADDR_STAT) |=> !mgmt_rdata[STAT_T4])
    else $error("four pair ability not zero");
  AST_DONE_READ: assert property ( // see R8
    mgmt_rd && hit(mgmt_addr, ADDR_STAT) |=>
      mgmt_rdata[STAT_DONE] == $past(negotiation_done))
    else $error("negotiation done read wrong");
  AST_FEF_READ: assert property ( // see R9
    mgmt_rd && hit(mgmt_addr, ADDR_STAT) |=>
      mgmt_rdata[STAT_FEF] == $past(stat_fef))
    else $error("far-end fault read wrong");
  AST_LINK_READ: assert property ( // see R11
    mgmt_rd && hit(mgmt_addr, ADDR_STAT) |=>
      mgmt_rdata[STAT_LINK] == $past(stat_link))
    else $error("link status read wrong");
  AST_CTRL_READ: assert property ( // see R18
    mgmt_rd && hit(mgmt_addr, ADDR_CTRL) |=>
      mgmt_rdata[CTRL_AN_ON] == $past(negotiation_on))
    else $error("negotiation enable read wrong");
  AST_ADV_READ: assert property ( // see R15
    mgmt_rd && hit(mgmt_addr, ADDR_ADV) |=>
      mgmt_rdata == $past(adv_word))
    else $error("negotiation_advertise read wrong");
  AST_LP_READ: assert property ( // see R17
    mgmt_rd && hit(mgmt_addr, ADDR_LP) |=>
      mgmt_rdata[LP_PAUSE] == $past(lp_pause))
    else $error("partner pause read wrong");
  AST_ADV_HOLD: assert property ( // see R13 R14
    !wr_adv |=> $stable(adv_word))
    else $error("negotiation_advertise changed without write");
  AST_READ_ANSWER: assert property ( // see R12
    mgmt_rd |=> mgmt_rvalid)
    else $error("read not answered");

  // Coverage of the main scenarios

  COV_CTRL_WRITE: cover property (wr_ctrl ##1 transmit_off);
  COV_LINK_UP: cover property ($rose(stat_link) ##[1:20] negotiation_done);
  COV_LP_PAUSE: cover property (partner_valid ##1 partner_pause);
  COV_STAT_READ: cover property (
    mgmt_rd && hit(mgmt_addr, ADDR_STAT) ##1 mgmt_rdata[STAT_LINK]);
  COV_ADV_WRITE: cover property (wr_adv ##1 !adv_word[ADV_PAUSE]);

endmodule

// file: logic/pmr_partner_capture.sv
`timescale 1ns/100ps
module pmr_partner_capture (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic link_up,
  input wire logic word_valid,
  input wire logic [15:0] word,
  output logic pause,
  output logic [3:0] abil
);
  import pmr_pkg::*;

  // ----------------------------------------------------------------
  // Partner code word capture
  // ----------------------------------------------------------------
  logic next_pause;
  logic [3:0] next_abil;

  // Latch on a received word, forget when the link drops
  assign next_pause = word_valid ? word[LP_PAUSE] :
                      (link_up ? pause : 1'h0); // see R17
  assign next_abil = word_valid ? word[ADV_ABIL_HI:ADV_ABIL_LO] :
                     (link_up ? abil : 4'h0);

  // Captured fields
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pause <= 1'h0;
      abil <= 4'h0;
    end else begin
      pause <= next_pause;
      abil <= next_abil;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_LP_PAUSE: assert property (@(posedge clk_sys) disable iff (!arst_n) // see R17
    word_valid |=> pause == $past(word[LP_PAUSE]))
    else $error("partner pause not captured");

endmodule

// file: logic/pmr_pkg.sv
package pmr_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STAT = 5'h01;
  localparam logic [4:0] ADDR_IDH = 5'h02;
  localparam logic [4:0] ADDR_IDL = 5'h03;
  localparam logic [4:0] ADDR_ADV = 5'h04;
  localparam logic [4:0] ADDR_LP = 5'h05;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTRL_AN_ON = 12;
  localparam int CTRL_XOVER_OFF = 3;
  localparam int CTRL_FEF_OFF = 2;
  localparam int CTRL_TX_OFF = 1;
  localparam int CTRL_LED_OFF = 0;
  localparam logic RST_AN_ON = 1'h1;
  localparam logic RST_CTRL_LOW = 1'h0;

  // ----------------------------------------------------------------
  // Status field positions and fixed values
  // ----------------------------------------------------------------
  localparam int STAT_T4 = 15;
  localparam int STAT_CAP_HI = 14;
  localparam int STAT_CAP_LO = 11;
  localparam int STAT_RSV_HI = 10;
  localparam int STAT_RSV_LO = 7;
  localparam int STAT_DONE = 5;
  localparam int STAT_FEF = 4;
  localparam int STAT_AN_ABLE = 3;
  localparam int STAT_LINK = 2;
  localparam int STAT_EXT = 0;
  localparam logic [3:0] STAT_CAP_VAL = 4'hF;

  // ----------------------------------------------------------------
  // Negotiation_advertise and partner ability layout
  // ----------------------------------------------------------------
  localparam int ADV_PAUSE = 10;
  localparam int ADV_ABIL_HI = 8;
  localparam int ADV_ABIL_LO = 5;
  localparam int ADV_SEL_HI = 4;
  localparam logic RST_ADV_PAUSE = 1'h1;
  localparam logic [3:0] RST_ADV_ABIL = 4'hF;
  localparam logic [4:0] SEL_8023 = 5'h01;
  localparam int LP_PAUSE = 10;

  // Identifier defaults, values arbitrary
  localparam logic [15:0] ID_HIGH_DEF = 16'hA5C3;
  localparam logic [15:0] ID_LOW_DEF = 16'h3C5A;

endpackage

// file: verif/pmr_smc_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Station management controller model
// ----------------------------------------------------------------
module pmr_smc_model (
  input wire logic clk_sys,
  input wire logic [pmr_pkg::DATA_W-1:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  output logic [pmr_pkg::ADDR_W-1:0] mgmt_addr,
  output logic mgmt_wr,
  output logic mgmt_rd,
  output logic [pmr_pkg::DATA_W-1:0] mgmt_wdata
);
  import pmr_pkg::*;

  // Idle bus at time zero
  initial begin
    mgmt_addr = 5'h00;
    mgmt_wr = 1'h0;
    mgmt_rd = 1'h0;
    mgmt_wdata = 16'h0000;
  end

  // One write after gap idle cycles; lines scrambled once released
  task automatic wr_reg(input int gap, input logic [4:0] a,
                        input logic [15:0] d);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    mgmt_addr <= a;
    mgmt_wdata <= d;
    mgmt_wr <= 1'h1;
    @(posedge clk_sys);
    mgmt_wr <= 1'h0;
    mgmt_addr <= ~a;
    mgmt_wdata <= ~d;
  endtask

  // One read; answer taken at the edge showing the valid pulse
  task automatic rd_reg(input int gap, input logic [4:0] a,
                        output logic [15:0] d);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    mgmt_addr <= a;
    mgmt_rd <= 1'h1;
    @(posedge clk_sys);
    mgmt_rd <= 1'h0;
    mgmt_addr <= ~a;
    d = 'x;
    for (int n = 0; n < 4; n++) begin
      @(posedge clk_sys);
      if (mgmt_rvalid === 1'h1) begin
        d = mgmt_rdata;
        break;
      end
    end
  endtask
endmodule

// file: verif/tb.sv
`timescale 1ns/100ps
module tb;
  import pmr_pkg::*;
  // Identifier values, arbitrary
  localparam logic [15:0] IDH = 16'h1E2D;
  localparam logic [15:0] IDL = 16'h4B78;
  logic clk_sys = 1'h0;
  logic arst_n = 1'h0;
  logic [4:0] mgmt_addr;
  logic mgmt_wr, mgmt_rd, mgmt_rvalid;
  logic [15:0] mgmt_wdata, mgmt_rdata, adv_word;
  logic an_done_in = 1'h0;
  logic far_fault_in = 1'h0;
  logic link_up_in = 1'h0;
  logic partner_valid = 1'h0;
  logic [15:0] partner_word = 16'h0000;
  logic crossover_auto_off, fef_detect_off, transmit_off;
  logic indicator_off, negotiation_on, partner_pause;
  int num_errors = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h10154204;
  logic [15:0] ctrl_e, adv_e, lp_e, r, w;
  logic [4:0] a;

  always #4 clk_sys = ~clk_sys;

  pmr_bank #(.ID_HIGH(IDH), .ID_LOW(IDL)) dut (.clk_sys(clk_sys),
    .arst_n(arst_n), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
    .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .an_done_in(an_done_in),
    .far_fault_in(far_fault_in), .link_up_in(link_up_in),
    .partner_valid(partner_valid), .partner_word(partner_word),
    .crossover_auto_off(crossover_auto_off),
    .fef_detect_off(fef_detect_off), .transmit_off(transmit_off),
    .indicator_off(indicator_off), .negotiation_on(negotiation_on),
    .adv_word(adv_word), .partner_pause(partner_pause));

  pmr_smc_model smc (.clk_sys(clk_sys), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
    .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata));

  // Xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // Expected register image per address
  function automatic logic [15:0] exp_reg(input logic [4:0] ad);
    case (ad)
      ADDR_CTRL: return ctrl_e;
      ADDR_STAT: return 16'h7808 | {10'h000, an_done_in & ctrl_e[12],
        far_fault_in & ~ctrl_e[2], 1'h0, link_up_in, 2'h0};
      ADDR_IDH: return IDH;
      ADDR_IDL: return IDL;
      ADDR_ADV: return adv_e;
      ADDR_LP: return lp_e;
      default: return 16'h0000;
    endcase
  endfunction

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Outputs that mirror the control, negotiation_advertise and partner registers
  task automatic check_out;
    check(16'(crossover_auto_off), 16'(ctrl_e[3]));
    check(16'(fef_detect_off), 16'(ctrl_e[2]));
    check(16'(transmit_off), 16'(ctrl_e[1]));
    check(16'(indicator_off), 16'(ctrl_e[0]));
    check(16'(negotiation_on), 16'(ctrl_e[12]));
    check(adv_word, adv_e);
    check(16'(partner_pause), 16'(lp_e[10]));
  endtask

  // Read every mapped address and one unmapped
  task automatic check_all;
    logic [4:0] k;
    for (int i = 0; i < 7; i++) begin
      k = (i == 6) ? 5'h1F : 5'(i);
      smc.rd_reg(i % 3, k, r);
      check(r, exp_reg(k));
    end
    check_out();
  endtask

  task automatic results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    results();
  end

  // Main sequence: reset values, corners, then random traffic
  initial begin
    ctrl_e = 16'h1000;
    adv_e = 16'h05E1;
    lp_e = 16'h0001;
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'h1;
    check_all();
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 :
          (i == 2) ? 16'h000F : 16'hEFF0;
      for (int j = 0; j < 6; j++) begin
        smc.wr_reg(0, 5'(j), w ^ 16'(j));
      end
      ctrl_e = (w ^ 16'h0000) & 16'h100F;
      adv_e = ((w ^ 16'h0004) & 16'h05E0) | 16'h0001;
      check_all();
    end
    for (int i = 0; i < 60; i++) begin
      seed = xs(seed);
      a = {2'h0, seed[18:16]};
      smc.wr_reg(seed[20], a, seed[15:0]);
      if (a == ADDR_CTRL) ctrl_e = seed[15:0] & 16'h100F;
      if (a == ADDR_ADV) adv_e = (seed[15:0] & 16'h05E0) | 16'h0001;
      w = {seed[7:0], seed[31:24]};
      @(posedge clk_sys);
      an_done_in <= seed[29];
      far_fault_in <= seed[30];
      link_up_in <= seed[31];
      partner_valid <= seed[31] & seed[28];
      partner_word <= w;
      @(posedge clk_sys);
      partner_valid <= 1'h0;
      partner_word <= ~w;
      if (!seed[31]) lp_e = 16'h0001;
      else if (seed[28]) lp_e = {5'h00, w[10], 1'h0, w[8:5], 5'h01};
      repeat (2) @(posedge clk_sys);
      seed = xs(seed);
      a = {2'h0, seed[2:0]};
      smc.rd_reg(seed[3], a, r);
      check(r, exp_reg(a));
      check_out();
      if (i % 15 == 14) check_all();
    end
    results();
  end
endmodule
